// ==== ext_bus_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_map.svh"
module ext_bus_sequencer (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        req_valid_i,
	input  wire logic [28:0] req_addr_i,
	input  wire logic        req_write_i,
	input  wire logic [1:0]  req_size_i,
	input  wire logic        req_lock_i,
	input  wire logic        req_writeback_i,
	input  wire logic        req_dma16_dual_wr_i,
	input  wire logic        req_dma_acknowledge_xfer_i,
	output logic             req_done_o,
	output logic      [25:0] addr_o,
	output logic      [6:0]  area_select_n_o,
	output logic             read_n_o,
	output logic             write_n_o,
	output logic             card_io_cycle_o,
	input  wire logic        wait_n_i,
	input  wire logic        io_is_16bit_input_n_i,
	input  wire logic        bus_release_request_n_i,
	output logic             bus_grant_n_o,
	output logic             bus_retrieve_request_n_o,
	input  wire logic        refresh_pending_i,
	input  wire logic [3:0]  irq_level_i,
	input  wire logic [3:0]  irq_mask_i
);
	logic [31:0] bus_control_one;
	logic [31:0] bus_control_two;
	logic [31:0] wait_control_one;
	logic [31:0] wait_control_two;

	ext_bus_pkg::seq_state_t   state;
	ext_bus_pkg::access_size_t acc_size;
	logic [28:0] acc_addr;
	logic [2:0]  acc_area;
	logic        acc_write;
	logic        acc_io;
	logic        acc_burst;
	logic        acc_ignore_wait;
	logic        acc_lock;
	logic [1:0]  acc_width;
	logic [2:0]  acc_ws;
	logic [4:0]  beats_left;
	logic        first_beat;
	logic [2:0]  cyc_cnt;
	logic [1:0]  gap_cnt;
	logic        lock_held;

	ext_seq_if seq ();

	idle_gap_tracker u_gap (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.seq    (seq)
	);

	bus_arbiter u_arb (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.seq    (seq)
	);

	// Register slave decode.
	wire sel_one    = avs_address_i == `BUS_CONTROL_ONE_ADDR;
	wire sel_two    = avs_address_i == `BUS_CONTROL_TWO_ADDR;
	wire sel_wone   = avs_address_i == `WAIT_CONTROL_ONE_ADDR;
	wire sel_wtwo   = avs_address_i == `WAIT_CONTROL_TWO_ADDR;
	wire sel_status = avs_address_i == `SEQ_STATUS_ADDR;
	wire wr_take    = avs_write_i && !avs_waitrequest_o;
	wire rd_launch  = avs_read_i && avs_waitrequest_o;
	wire [31:0] status_word = {27'h0000000, lock_held, state,
		state != ext_bus_pkg::ST_IDLE, seq.granted};
	wire [31:0] read_value = sel_one ? bus_control_one :
		sel_two ? bus_control_two :
		sel_wone ? wait_control_one :
		sel_wtwo ? wait_control_two :
		sel_status ? status_word : 32'h00000000;
	wire little_endian = bus_control_one[`LITTLE_ENDIAN_BIT];

	// Decode of the pending request against the current configuration.
	wire [2:0] new_area = req_addr_i[`AREA_MSB:`AREA_LSB];
	wire       is_a0    = new_area == `AREA_0;
	wire       is_a5    = new_area == `AREA_5;
	wire       is_a6    = new_area == `AREA_6;
	wire       card5    = is_a5 && bus_control_one[`A5_CARD_BIT];
	wire       card6    = is_a6 && bus_control_one[`A6_CARD_BIT];
	wire       new_card = card5 || card6;
	wire       in_io5   = req_addr_i >= `AREA5_IO_LO &&
		req_addr_i <= `AREA5_IO_HI;
	wire       in_io6   = req_addr_i >= `AREA6_IO_LO &&
		req_addr_i <= `AREA6_IO_HI;
	wire       new_io   = (card5 && in_io5) || (card6 && in_io6);
	wire [1:0] raw_width = bus_control_two[{new_area, 1'b0} +: 2];
	// A card port whose field holds the 32-bit code runs 16 bits wide; other codes pass through.
	wire [1:0] new_width = (new_card && raw_width == `WIDTH_32) ?
		`WIDTH_16 : raw_width;
	wire [1:0] burst_code = is_a0 ?
		bus_control_one[`A0_BURST_LSB +: 2] :
		is_a5 ? bus_control_one[`A5_BURST_LSB +: 2] :
		is_a6 ? bus_control_one[`A6_BURST_LSB +: 2] : 2'h0;
	// Bursts are read-only and never run as I/O card cycles.
	wire new_burst = burst_code != 2'h0 && !req_write_i && !new_io;
	wire [4:0] new_beats = new_burst ?
		ext_bus_pkg::burst_len(new_width, burst_code) :
		ext_bus_pkg::split_beats(ext_bus_pkg::access_size_t'(req_size_i),
			new_width);
	wire [4:0] ws_base = 5'(new_area) * `WAIT_FIELD_W;
	wire [2:0] new_ws  = wait_control_two[ws_base +: 3];
	wire new_ignore = req_writeback_i || req_dma16_dual_wr_i ||
		req_dma_acknowledge_xfer_i;

	// Start and release are mutually exclusive at an idle boundary.
	wire start = state == ext_bus_pkg::ST_IDLE && req_valid_i &&
		!req_done_o && !seq.granted &&
		(bus_release_request_n_i || lock_held);

	// Wait sampling and beat sequencing.
	wire sample_wait = !acc_ignore_wait &&
		(!first_beat || acc_ws != 3'h0);
	wire held_off    = sample_wait && !wait_n_i;
	wire beat_end    = state == ext_bus_pkg::ST_ACCESS &&
		cyc_cnt == 3'h0 && !held_off;
	// The 16-bit I/O input is only honoured in little-endian mode; the
	// outside keeps it low otherwise.
	wire dyn_split = first_beat && acc_io && little_endian &&
		acc_width == `WIDTH_16 && acc_size == ext_bus_pkg::SIZE_WORD &&
		io_is_16bit_input_n_i;
	wire last_beat = beat_end && beats_left == 5'h01 && !dyn_split;
	wire [4:0] step = dyn_split ? 5'h01 :
		ext_bus_pkg::port_bytes(acc_width);
	// Later burst beats with no programmed wait still take two cycles.
	wire [2:0] later_reload = (acc_burst && acc_ws == 3'h0) ?
		3'h1 : acc_ws;

	assign seq.access_begin      = start;
	assign seq.access_end        = last_beat;
	assign seq.begin_area        = new_area;
	assign seq.begin_write       = req_write_i;
	assign seq.idle_counts       = wait_control_one[13:0];
	// Split and burst beats all sit inside ST_ACCESS, so the arbiter only
	// sees an idle, unlocked sequencer.
	assign seq.may_release       = state == ext_bus_pkg::ST_IDLE &&
		!lock_held;
	assign seq.release_request_n = bus_release_request_n_i;
	assign seq.refresh_pending   = refresh_pending_i;
	assign seq.irq_level         = irq_level_i;
	assign seq.irq_mask          = irq_mask_i;
	assign bus_grant_n_o         = seq.grant_n;
	assign bus_retrieve_request_n_o = seq.retrieve_n;

	// Register slave: one wait cycle, then a single-cycle answer.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
				avs_waitrequest_o);
			if (rd_launch)
				avs_readdata_o <= read_value;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bus_control_one  <= `BUS_CONTROL_ONE_RST;
			bus_control_two  <= `BUS_CONTROL_TWO_RST;
			wait_control_one <= `WAIT_CONTROL_ONE_RST;
			wait_control_two <= `WAIT_CONTROL_TWO_RST;
		end else if (wr_take) begin
			if (sel_one)
				bus_control_one <= avs_writedata_i;
			if (sel_two)
				bus_control_two <= avs_writedata_i;
			if (sel_wone)
				wait_control_one <= avs_writedata_i;
			if (sel_wtwo)
				wait_control_two <= avs_writedata_i;
		end
	end

	// Access attributes are frozen at start so register writes during an
	// access can change its shape halfway only through the little-endian bit, read live for the I/O split.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc_addr        <= 29'h00000000;
			acc_area        <= 3'h0;
			acc_write       <= 1'b0;
			acc_io          <= 1'b0;
			acc_burst       <= 1'b0;
			acc_ignore_wait <= 1'b0;
			acc_lock        <= 1'b0;
			acc_ws          <= 3'h0;
			acc_size        <= ext_bus_pkg::SIZE_BYTE;
		end else if (start) begin
			acc_addr        <= req_addr_i;
			acc_area        <= new_area;
			acc_write       <= req_write_i;
			acc_io          <= new_io;
			acc_burst       <= new_burst;
			acc_ignore_wait <= new_ignore;
			acc_lock        <= req_lock_i;
			acc_ws          <= new_ws;
			acc_size        <= ext_bus_pkg::access_size_t'(req_size_i);
		end else if (beat_end && !last_beat) begin
			acc_addr        <= acc_addr + 29'(step);
		end
	end

	// A locked read keeps the bus until the access that follows it ends.
	always_ff @(posedge clk_i) begin
		if (srst_i)
			lock_held <= 1'b0;
		else if (last_beat)
			lock_held <= acc_lock;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state           <= ext_bus_pkg::ST_IDLE;
			acc_width       <= `WIDTH_32;
			beats_left      <= 5'h00;
			first_beat      <= 1'b0;
			cyc_cnt         <= 3'h0;
			gap_cnt         <= 2'h0;
			req_done_o      <= 1'b0;
			addr_o          <= 26'h0000000;
			area_select_n_o <= 7'h7f;
			read_n_o        <= 1'b1;
			write_n_o       <= 1'b1;
			card_io_cycle_o <= 1'b0;
		end else begin
			req_done_o <= last_beat;
			case (state)
			ext_bus_pkg::ST_IDLE: begin
				if (start) begin
					state      <= ext_bus_pkg::ST_SETUP;
					gap_cnt    <= seq.gap_cycles;
					acc_width  <= new_width;
					beats_left <= new_beats;
				end else if (seq.granted) begin
					state <= ext_bus_pkg::ST_HELD;
				end
			end
			ext_bus_pkg::ST_SETUP: begin
				if (gap_cnt == 2'h0) begin
					state           <= ext_bus_pkg::ST_ACCESS;
					first_beat      <= 1'b1;
					cyc_cnt         <= acc_ws;
					addr_o          <= acc_addr[25:0];
					area_select_n_o <= ~(7'h01 << acc_area);
					read_n_o        <= acc_write;
					write_n_o       <= !acc_write;
					card_io_cycle_o <= acc_io;
				end else begin
					gap_cnt <= gap_cnt - 2'h1;
				end
			end
			ext_bus_pkg::ST_ACCESS: begin
				if (last_beat) begin
					state           <= ext_bus_pkg::ST_IDLE;
					area_select_n_o <= 7'h7f;
					read_n_o        <= 1'b1;
					write_n_o       <= 1'b1;
					card_io_cycle_o <= 1'b0;
				end else if (beat_end) begin
					first_beat <= 1'b0;
					cyc_cnt    <= later_reload;
					addr_o     <= acc_addr[25:0] + 26'(step);
					if (dyn_split)
						acc_width <= `WIDTH_8;
					else
						beats_left <= beats_left - 5'h01;
				end else if (cyc_cnt != 3'h0) begin
					cyc_cnt <= cyc_cnt - 3'h1;
				end
			end
			ext_bus_pkg::ST_HELD: begin
				if (!seq.granted)
					state <= ext_bus_pkg::ST_IDLE;
			end
			default: begin
				state <= ext_bus_pkg::ST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== ext_bus_map.svh ====
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define BUS_CONTROL_ONE_ADDR  5'h00
`define BUS_CONTROL_TWO_ADDR  5'h04
`define WAIT_CONTROL_ONE_ADDR 5'h08
`define WAIT_CONTROL_TWO_ADDR 5'h0c
`define SEQ_STATUS_ADDR       5'h10
`define BUS_CONTROL_ONE_RST   32'h00000000
`define BUS_CONTROL_TWO_RST   32'h00003fff
`define WAIT_CONTROL_ONE_RST  32'h00003fff
`define WAIT_CONTROL_TWO_RST  32'h00000000
`define A0_BURST_LSB          0
`define A5_BURST_LSB          2
`define A6_BURST_LSB          4
`define A5_CARD_BIT           6
`define A6_CARD_BIT           7
`define LITTLE_ENDIAN_BIT     8
`define WIDTH_8               2'h1
`define WIDTH_16              2'h2
`define WIDTH_32              2'h3
`define AREA_0                3'h0
`define AREA_5                3'h5
`define AREA_6                3'h6
`define AREA_MSB              28
`define AREA_LSB              26
`define WAIT_FIELD_W          5'h03
`define AREA5_IO_LO           29'h16000000
`define AREA5_IO_HI           29'h17ffffff
`define AREA6_IO_LO           29'h1a000000
`define AREA6_IO_HI           29'h1bffffff
`define EMPTY_SAT             2'h3
`endif

// ==== ext_bus_pkg.sv ====
`include "ext_bus_map.svh"
package ext_bus_pkg;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_SETUP  = 2'h1,
		ST_ACCESS = 2'h3,
		ST_HELD   = 2'h2
	} seq_state_t;
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2,
		SIZE_LINE = 2'h3
	} access_size_t;
	function automatic logic [4:0] port_bytes(input logic [1:0] width);
		port_bytes = (width == `WIDTH_8) ? 5'h01 :
			(width == `WIDTH_16) ? 5'h02 : 5'h04;
	endfunction
	function automatic logic [4:0] size_bytes(input access_size_t size);
		size_bytes = (size == SIZE_BYTE) ? 5'h01 : (size == SIZE_WORD) ?
			5'h02 : (size == SIZE_LONG) ? 5'h04 : 5'h10;
	endfunction
	function automatic logic [4:0] split_beats(input access_size_t size,
			input logic [1:0] width);
		split_beats = (size_bytes(size) <= port_bytes(width)) ? 5'h01 :
			5'(size_bytes(size) / port_bytes(width));
	endfunction
	// Codes above the widest legal burst for the port clamp to it.
	function automatic logic [4:0] burst_len(input logic [1:0] width,
			input logic [1:0] code);
		if (width == `WIDTH_8)
			burst_len = (code == 2'h1) ? 5'h04 : (code == 2'h2) ? 5'h08 : 5'h10;
		else if (width == `WIDTH_16)
			burst_len = (code == 2'h1) ? 5'h04 : 5'h08;
		else
			burst_len = 5'h04;
	endfunction
endpackage

// ==== ext_seq_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ext_seq_if;
	logic       access_begin;
	logic       access_end;
	logic [2:0] begin_area;
	logic       begin_write;
	logic [13:0] idle_counts;
	logic [1:0] gap_cycles;
	logic       may_release;
	logic       granted;
	logic       release_request_n;
	logic       refresh_pending;
	logic [3:0] irq_level;
	logic [3:0] irq_mask;
	logic       grant_n;
	logic       retrieve_n;
	modport seq (output access_begin, access_end, begin_area, begin_write,
		idle_counts, may_release, release_request_n, refresh_pending,
		irq_level, irq_mask, input gap_cycles, granted, grant_n, retrieve_n);
	modport gap (input access_begin, access_end, begin_area, begin_write,
		idle_counts, granted, output gap_cycles);
	modport arb (input may_release, release_request_n, refresh_pending,
		irq_level, irq_mask, output granted, grant_n, retrieve_n);
endinterface
`default_nettype wire

// ==== idle_gap_tracker.sv ====
`timescale 1ns/100ps
`default_nettype none
module idle_gap_tracker (
	input  wire logic clk_i,
	input  wire logic srst_i,
	ext_seq_if.gap    seq
);
	logic [2:0] prev_area;
	logic       prev_write;
	logic       prev_valid;
	logic       busy;
	logic [1:0] empty_cnt;
	wire [1:0] prog_idle = seq.idle_counts[{prev_area, 1'b0} +: 2];
	wire       collide   = prev_valid && (seq.begin_area != prev_area ||
		(seq.begin_write && !prev_write));
	assign seq.gap_cycles = !collide ? 2'h0 :
		(prog_idle > empty_cnt) ? prog_idle - empty_cnt : 2'h0;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prev_area  <= 3'h0;
			prev_write <= 1'b0;
			prev_valid <= 1'b0;
			busy       <= 1'b0;
			empty_cnt  <= 2'h0;
		end else begin
			if (seq.granted) begin
				prev_valid <= 1'b0;
			end else if (seq.access_begin) begin
				prev_area  <= seq.begin_area;
				prev_write <= seq.begin_write;
				prev_valid <= 1'b1;
			end
			if (seq.access_begin)
				busy <= 1'b1;
			else if (seq.access_end)
				busy <= 1'b0;
			if (seq.access_end)
				empty_cnt <= 2'h0;
			else if (!busy && empty_cnt != `EMPTY_SAT)
				empty_cnt <= empty_cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ==== bus_arbiter.sv ====
`timescale 1ns/100ps
`default_nettype none
module bus_arbiter (
	input  wire logic clk_i,
	input  wire logic srst_i,
	ext_seq_if.arb    seq
);
	// Grant is taken only at an access boundary, so a cycle is never cut.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			seq.granted    <= 1'b0;
			seq.grant_n    <= 1'b1;
			seq.retrieve_n <= 1'b1;
		end else begin
			if (!seq.granted && !seq.release_request_n && seq.may_release) begin
				seq.granted <= 1'b1;
				seq.grant_n <= 1'b0;
			end else if (seq.granted && seq.release_request_n) begin
				seq.granted <= 1'b0;
				seq.grant_n <= 1'b1;
			end
			seq.retrieve_n <= !(seq.refresh_pending ||
				seq.irq_level > seq.irq_mask);
		end
	end
endmodule
`default_nettype wire

// ==== ext_bus_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module ext_bus_monitor (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [25:0] addr_o,
	input  wire logic [6:0]  area_select_n_o,
	input  wire logic        read_n_o,
	input  wire logic        write_n_o,
	input  wire logic        card_io_cycle_o,
	input  wire logic        bus_release_request_n_i,
	input  wire logic        bus_grant_n_o,
	input  wire logic        bus_retrieve_request_n_o,
	input  wire logic        refresh_pending_i,
	input  wire logic [3:0]  irq_level_i,
	input  wire logic [3:0]  irq_mask_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	wire irq_beats = irq_level_i > irq_mask_i;
	wire strobe    = !read_n_o || !write_n_o;
	sequence held_grant_s;
		!bus_grant_n_o && bus_release_request_n_i;
	endsequence
	sequence read_on_s;
		!read_n_o ##1 !read_n_o;
	endsequence
	chk_grant_cause: assert property ($fell(bus_grant_n_o) |->
		!$past(bus_release_request_n_i)) else $error("grant unasked");
	chk_grant_drops: assert property (held_grant_s |=> bus_grant_n_o)
		else $error("grant kept after request removed");
	chk_bus_quiet: assert property (!bus_grant_n_o |-> !strobe &&
		area_select_n_o == 7'h7f) else $error("cycle while granted");
	chk_refresh_pull: assert property (refresh_pending_i |=>
		!bus_retrieve_request_n_o) else $error("retrieve missed refresh");
	chk_irq_pull: assert property (irq_beats |=>
		!bus_retrieve_request_n_o) else $error("retrieve missed irq");
	chk_retrieve_quiet: assert property (!refresh_pending_i && !irq_beats
		|=> bus_retrieve_request_n_o) else $error("retrieve without cause");
	chk_burst_select: assert property (read_on_s |->
		$stable(area_select_n_o)) else $error("select moved in access");
	chk_card_window: assert property (card_io_cycle_o && strobe |->
		addr_o[25] && !(area_select_n_o[5] && area_select_n_o[6]))
		else $error("io cycle outside window");
endmodule
bind ext_bus_sequencer ext_bus_monitor ext_bus_monitor_i (.clk_i(clk_i),
	.srst_i(srst_i), .addr_o(addr_o), .area_select_n_o(area_select_n_o),
	.read_n_o(read_n_o), .write_n_o(write_n_o),
	.card_io_cycle_o(card_io_cycle_o),
	.bus_release_request_n_i(bus_release_request_n_i),
	.bus_grant_n_o(bus_grant_n_o),
	.bus_retrieve_request_n_o(bus_retrieve_request_n_o),
	.refresh_pending_i(refresh_pending_i), .irq_level_i(irq_level_i),
	.irq_mask_i(irq_mask_i));
`default_nettype wire

// ==== ext_bus_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module ext_bus_partner (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       strobe_n_i,
	input  wire logic       bus_retrieve_request_n_i,
	input  wire logic       want_bus_i,
	input  wire logic       narrow_io_i,
	input  wire logic       little_endian_i,
	input  wire logic [3:0] stall_i,
	output logic            wait_n_o,
	output logic            io_is_16bit_input_n_o,
	output logic            bus_release_request_n_o
);
	logic [3:0] left;
	logic       dropped;
	logic       strobe_q;
	// The stall starts one cycle into the access, so a zero-wait first
	// burst beat never sees it while the second beat does.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			left <= 4'h0;
			dropped <= 1'b0;
			strobe_q <= 1'b1;
		end else begin
			strobe_q <= strobe_n_i;
			if (strobe_q && !strobe_n_i)
				left <= stall_i;
			else if (left != 4'h0)
				left <= left - 4'h1;
			if (!want_bus_i)
				dropped <= 1'b0;
			else if (!bus_retrieve_request_n_i)
				dropped <= 1'b1;
		end
	end
	assign wait_n_o = (left == 4'h0);
	assign io_is_16bit_input_n_o = narrow_io_i && little_endian_i;
	assign bus_release_request_n_o = !(want_bus_i && !dropped);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ext_bus_map.svh"
module tb_top;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [4:0]  avs_address_i = 5'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        req_valid_i = 1'b0;
	logic [28:0] req_addr_i = 29'h0;
	logic        req_write_i = 1'b0;
	logic [1:0]  req_size_i = 2'h0;
	logic        req_writeback_i = 1'b0;
	logic        req_done_o;
	logic [25:0] addr_o;
	logic [6:0]  area_select_n_o;
	logic        read_n_o;
	logic        write_n_o;
	logic        card_io_cycle_o;
	logic        wait_n_i;
	logic        io16_n;
	logic        release_n;
	logic        bus_grant_n_o;
	logic        retrieve_n;
	logic        refresh_pending_i = 1'b0;
	logic [3:0]  irq_level_i = 4'h0;
	logic [3:0]  irq_mask_i = 4'hf;
	logic        want_bus = 1'b0;
	logic        lock = 1'b0;
	int          lat;
	logic        narrow = 1'b0;
	logic [3:0]  stall = 4'h0;
	logic [31:0] q;
	int          fails = 0;
	int          compares = 0;
	int          beats;
	int          cyc;
	logic        io;
	logic        held;
	always #12.5 clk_i = ~clk_i;
	ext_bus_sequencer ext_bus_sequencer_i (.clk_i(clk_i), .srst_i(srst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.req_valid_i(req_valid_i), .req_addr_i(req_addr_i),
		.req_write_i(req_write_i), .req_size_i(req_size_i), .req_lock_i(lock),
		.req_writeback_i(req_writeback_i), .req_dma16_dual_wr_i(1'b0),
		.req_dma_acknowledge_xfer_i(1'b0), .req_done_o(req_done_o),
		.addr_o(addr_o), .area_select_n_o(area_select_n_o),
		.read_n_o(read_n_o), .write_n_o(write_n_o),
		.card_io_cycle_o(card_io_cycle_o), .wait_n_i(wait_n_i),
		.io_is_16bit_input_n_i(io16_n), .bus_release_request_n_i(release_n),
		.bus_grant_n_o(bus_grant_n_o), .bus_retrieve_request_n_o(retrieve_n),
		.refresh_pending_i(refresh_pending_i), .irq_level_i(irq_level_i),
		.irq_mask_i(irq_mask_i));
	ext_bus_partner ext_bus_partner_i (.clk_i(clk_i), .srst_i(srst_i),
		.strobe_n_i(read_n_o && write_n_o), .bus_retrieve_request_n_i(retrieve_n),
		.want_bus_i(want_bus), .narrow_io_i(narrow), .little_endian_i(1'b1),
		.stall_i(stall), .wait_n_o(wait_n_i), .io_is_16bit_input_n_o(io16_n),
		.bus_release_request_n_o(release_n));
	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp,
			input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic reg_op(input logic wr, input logic [4:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20)
			fails++;
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Counts strobe cycles and beats (fresh strobe or new address).
	task automatic access(input logic [28:0] a, input logic wr,
			input logic [1:0] sz, input logic wb);
		int n;
		logic [25:0] pa;
		logic ps;
		n = 0;
		ps = 1'b1;
		pa = 26'h0;
		beats = 0;
		cyc = 0;
		lat = 0;
		io = 1'b0;
		held = 1'b1;
		req_addr_i <= a;
		req_write_i <= wr;
		req_size_i <= sz;
		req_writeback_i <= wb;
		req_valid_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (!(read_n_o && write_n_o)) begin
				cyc++;
				if (cyc == 1)
					lat = n;
				if (ps || addr_o !== pa)
					beats++;
				if (area_select_n_o === 7'h7f)
					held = 1'b0;
				if (card_io_cycle_o === 1'b1)
					io = 1'b1;
			end
			ps = read_n_o && write_n_o;
			pa = addr_o;
		end while (req_done_o !== 1'b1 && n < 200);
		if (n >= 200)
			fails++;
		req_valid_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic test_regs;
		reg_op(1'b0, `BUS_CONTROL_TWO_ADDR, 32'h0);
		expect_eq(q, `BUS_CONTROL_TWO_RST, "width reset");
		reg_op(1'b0, `WAIT_CONTROL_ONE_ADDR, 32'h0);
		expect_eq(q, `WAIT_CONTROL_ONE_RST, "idle reset");
		reg_op(1'b1, 5'h14, 32'hffffffff);
		reg_op(1'b0, 5'h14, 32'h0);
		expect_eq(q, 32'h0, "unmapped read");
		reg_op(1'b1, `BUS_CONTROL_TWO_ADDR, 32'h00002bfd);
		reg_op(1'b1, `WAIT_CONTROL_TWO_ADDR, 32'h00008000);
		reg_op(1'b1, `BUS_CONTROL_ONE_ADDR, 32'h000001d2);
		reg_op(1'b0, `BUS_CONTROL_ONE_ADDR, 32'h0);
		expect_eq(q, 32'h000001d2, "control readback");
	endtask
	// Area 0 is an 8-bit ROM, so the codes walk through 4, 8 and 16 beats.
	task automatic test_burst;
		for (int c = 1; c < 4; c++) begin
			reg_op(1'b1, `BUS_CONTROL_ONE_ADDR, 32'h000001d0 | c);
			access(29'h0, 1'b0, 2'h2, 1'b0);
			expect_eq(beats, 32'h2 << c, "burst beats");
			expect_eq(cyc, (32'h4 << c) - 1, "burst cycles");
			expect_eq(held, 1'b1, "burst select");
		end
		stall <= 4'h2;
		access(29'h0, 1'b0, 2'h2, 1'b0);
		expect_eq(cyc > 31, 1'b1, "burst wait ignored");
		stall <= 4'h0;
	endtask
	task automatic test_card;
		stall <= 4'h3;
		access(29'h14000000, 1'b0, 2'h0, 1'b0);
		expect_eq(cyc > 2, 1'b1, "card wait ignored");
		access(29'h14000000, 1'b1, 2'h0, 1'b1);
		expect_eq(cyc, 2, "writeback wait seen");
		expect_eq(lat > 3, 1'b1, "no idle gap");
		stall <= 4'h0;
		narrow <= 1'b1;
		access(29'h16000000, 1'b0, 2'h1, 1'b0);
		expect_eq(beats, 2, "io split");
		expect_eq(io, 1'b1, "io cycle");
		narrow <= 1'b0;
		access(29'h17fffffe, 1'b0, 2'h1, 1'b0);
		expect_eq(beats, 1, "io no split");
		expect_eq(io, 1'b1, "io top");
		access(29'h18000000, 1'b1, 2'h2, 1'b0);
		expect_eq(beats, 2, "card write burst");
		expect_eq(io, 1'b0, "memory cycle");
		access(29'h18000000, 1'b0, 2'h2, 1'b0);
		expect_eq(beats, 4, "card read burst");
		expect_eq(lat, 3, "needless gap");
	endtask
	task automatic test_arb;
		int n;
		n = 0;
		lock <= 1'b1;
		access(29'h0, 1'b0, 2'h0, 1'b0);
		lock <= 1'b0;
		// The request rises while the lock is held; the write must still run.
		want_bus <= 1'b1;
		access(29'h0, 1'b1, 2'h0, 1'b0);
		expect_eq(cyc > 0, 1'b1, "locked pair cut");
		do begin
			@(posedge clk_i);
			n++;
		end while (bus_grant_n_o !== 1'b0 && n < 10);
		expect_eq(bus_grant_n_o, 1'b0, "no grant");
		refresh_pending_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		expect_eq(retrieve_n, 1'b0, "no retrieve");
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (bus_grant_n_o !== 1'b1 && n < 10);
		expect_eq(bus_grant_n_o, 1'b1, "grant kept");
		want_bus <= 1'b0;
		refresh_pending_i <= 1'b0;
		irq_level_i <= 4'h5;
		irq_mask_i <= 4'h4;
		repeat (2) @(posedge clk_i);
		expect_eq(retrieve_n, 1'b0, "irq retrieve");
		irq_mask_i <= 4'h5;
		repeat (2) @(posedge clk_i);
		expect_eq(retrieve_n, 1'b1, "masked retrieve");
	endtask
	task automatic summarize;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		test_regs();
		test_burst();
		test_card();
		test_arb();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
